// ===== verilog/clkc_params.svh
`ifndef CLKC_PARAMS_SVH
`define CLKC_PARAMS_SVH
`define CLKC_SYNTH_CONTROL_ADDR 24'h120000
`define CLKC_SYNTH_STATUS_ADDR 24'h120002
`define CLKC_LOCK_RST_EN_BIT 15
`define CLKC_MULT_FLD_HI 14
`define CLKC_MULT_FLD_LO 12
`define CLKC_CTRL_RESET 16'h1000
`define CLKC_STAT_LOCK_BIT 3
`define CLKC_STAT_LOST_BIT 2
`define CLKC_STAT_MODE_HI 7
`define CLKC_STAT_MODE_LO 6
`define CLKC_LOCK_TIME_NS 1000
`define CLKC_CLK_PERIOD_NS 10
`define CLKC_LOCK_CYCLES ((`CLKC_LOCK_TIME_NS + `CLKC_CLK_PERIOD_NS - 1) / `CLKC_CLK_PERIOD_NS)
`define CLKC_MODE_NORMAL 2'h3
`define CLKC_MODE_ONE2ONE 2'h2
`define CLKC_MODE_EXT 2'h0
`endif

// ===== verilog/clkc_pkg.sv
package clkc_pkg;
  typedef enum logic [1:0] {CLKC_NORMAL, CLKC_ONE2ONE, CLKC_EXTERNAL} clkc_mode_t;
  typedef enum logic [1:0] {CLKC_UNLOCKED, CLKC_ACQUIRE, CLKC_LOCKED} clkc_lock_t;
endpackage

// ===== verilog/clkc_lock_if.sv
`timescale 1ns/10ps
interface clkc_lock_if;
  logic relock;
  logic bypass;
  logic locked;
  modport ctrl (output relock, output bypass, input locked);
  modport pll (input relock, input bypass, output locked);
endinterface

// ===== verilog/clkc_lock_model.sv
`timescale 1ns/10ps
`include "clkc_params.svh"
module clkc_lock_model #(
  parameter int LOCK_CYCLES = `CLKC_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Lock handshake
  clkc_lock_if.pll lk
);
  clkc_pkg::clkc_lock_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (lk.bypass) begin
      st_d = clkc_pkg::CLKC_LOCKED;
    end else if (lk.relock) begin
      st_d = clkc_pkg::CLKC_UNLOCKED;
      cnt_d = 32'h0;
    end else begin
      case (st_q)
        clkc_pkg::CLKC_UNLOCKED: begin
          st_d = clkc_pkg::CLKC_ACQUIRE;
          cnt_d = 32'h0;
        end
        clkc_pkg::CLKC_ACQUIRE: begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= 32'(LOCK_CYCLES - 1)) begin
            st_d = clkc_pkg::CLKC_LOCKED;
          end
        end
        default: st_d = st_q;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= clkc_pkg::CLKC_UNLOCKED;
      cnt_q <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
  assign lk.locked = (st_q == clkc_pkg::CLKC_LOCKED);
endmodule

// ===== verilog/clkc_top.sv
// Notes on behaviour
// - Oscillator output pin connects internal oscillator to the crystal.
// - Clock output pin toggles on every rising system clock edge while enabled, giving half the system clock rate.
// - Mode select inputs sampled at configuration choose clocking mode; held by outside.
// - Reset output asserts on internal reset or force-reset-output bit.
// - Control and status registers accessible only in supervisor mode.
// - Enabling lock-loss reset while unlocked in PLL modes resets immediately.
// - Lock-loss enable one resets on loss of lock; zero does not.
// - In external clock mode the lock-loss enable has no effect.
// - Control bits 14 to 12 hold the feedback divider value.
// - Changing multiplier or disabling PLL in stop loses lock; the code relocks on a multiplier change in normal mode only.
// - In 1:1 mode multiplier is ignored; factor is one.
// - In external mode multiplier does not affect clock.
// - Normal mode synthesizes two to nine times reference.
// - 1:1 mode output equals reference; post divider inactive.
// - External mode bypasses PLL; system clock equals input pin clock.
`timescale 1ns/10ps
`include "clkc_params.svh"
module clkc_top #(
  parameter int LOCK_CYCLES = `CLKC_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pins
  input wire logic osc_in_pin,
  output logic osc_out_pin,
  output logic sys_clock_out_pin,
  input wire logic sys_clock_out_en,
  input wire logic [1:0] clock_mode_select,
  output logic reset_out_pin,
  // Reset controller and stop control
  input wire logic force_reset_out_bit,
  input wire logic stop_pll_off,
  output logic lock_loss_reset_req,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_super,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // Clock status
  output logic [3:0] mult_factor,
  output logic pll_locked
);
  clkc_lock_if lk ();

  // Mode capture
  logic cfg_done_q, cfg_done_d;
  clkc_pkg::clkc_mode_t mode_q, mode_d;

  // Control register fields
  logic lock_rst_en_q, lock_rst_en_d;
  logic [2:0] mult_fld_q, mult_fld_d;
  logic relock_q, relock_d;

  // Lock tracking
  logic locked_prev_q, locked_prev_d;
  logic lost_q, lost_d;

  // Reset requests
  logic rst_req_q, rst_req_d;
  logic rst_out_q, rst_out_d;

  // Pin drivers
  logic osc_out_q, osc_out_d;
  logic clk_out_q, clk_out_d;

  // Register answer
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic err_q, err_d;

  // Multiplication factor
  logic [3:0] mult_q, mult_d;

  // Decodes
  logic hit_ctrl;
  logic hit_stat;
  logic pll_mode;
  logic ctrl_wr;
  logic lost_lock;

  // Feedback field to multiplication factor in normal mode
  function automatic logic [3:0] fld_to_mult(input logic [2:0] m);
    fld_to_mult = 4'h2 + {1'b0, m};
  endfunction

  // Mode select pins to clocking mode
  function automatic clkc_pkg::clkc_mode_t decode_mode(input logic [1:0] sel);
    case (sel)
      `CLKC_MODE_EXT: decode_mode = clkc_pkg::CLKC_EXTERNAL;
      `CLKC_MODE_ONE2ONE: decode_mode = clkc_pkg::CLKC_ONE2ONE;
      default: decode_mode = clkc_pkg::CLKC_NORMAL;
    endcase
  endfunction

  // Read image of the control register
  function automatic logic [15:0] ctrl_image(input logic en, input logic [2:0] m);
    logic [15:0] img;
    img = 16'h0;
    img[`CLKC_LOCK_RST_EN_BIT] = en;
    img[`CLKC_MULT_FLD_HI:`CLKC_MULT_FLD_LO] = m;
    ctrl_image = img;
  endfunction

  // Read image of the status register
  function automatic logic [15:0] stat_image(input clkc_pkg::clkc_mode_t md, input logic lk_now, input logic lost);
    logic [15:0] img;
    img = 16'h0;
    img[`CLKC_STAT_MODE_HI:`CLKC_STAT_MODE_LO] = 2'(md);
    img[`CLKC_STAT_LOCK_BIT] = lk_now;
    img[`CLKC_STAT_LOST_BIT] = lost;
    stat_image = img;
  endfunction

  // Address decode and write qualification
  assign hit_ctrl = reg_sel && (reg_addr == `CLKC_SYNTH_CONTROL_ADDR);
  assign hit_stat = reg_sel && (reg_addr == `CLKC_SYNTH_STATUS_ADDR);
  assign pll_mode = (mode_q != clkc_pkg::CLKC_EXTERNAL);
  assign ctrl_wr = hit_ctrl && reg_wr && reg_super;
  assign lost_lock = locked_prev_q && !lk.locked;

  // Lock handshake
  assign lk.relock = relock_q;
  assign lk.bypass = !pll_mode;

  clkc_lock_model #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lk(lk)
  );

  // Mode is taken once, at the first edge after reset
  always_comb begin
    cfg_done_d = 1'b1;
    mode_d = mode_q;
    if (!cfg_done_q) begin
      mode_d = decode_mode(clock_mode_select);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_done_q <= 1'b0;
      mode_q <= clkc_pkg::CLKC_NORMAL;
    end else begin
      cfg_done_q <= cfg_done_d;
      mode_q <= mode_d;
    end
  end

  // Control register; a changed multiplier field in normal mode forces the PLL to relock
  always_comb begin
    lock_rst_en_d = lock_rst_en_q;
    mult_fld_d = mult_fld_q;
    relock_d = 1'b0;
    if (ctrl_wr) begin
      lock_rst_en_d = reg_wdata[`CLKC_LOCK_RST_EN_BIT];
      mult_fld_d = reg_wdata[`CLKC_MULT_FLD_HI:`CLKC_MULT_FLD_LO];
      if ((mult_fld_d != mult_fld_q) && (mode_q == clkc_pkg::CLKC_NORMAL)) begin
        relock_d = 1'b1;
      end
    end
    if (stop_pll_off && pll_mode) begin
      relock_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_rst_en_q <= 1'b0;
      mult_fld_q <= 3'(`CLKC_CTRL_RESET >> `CLKC_MULT_FLD_LO);
      relock_q <= 1'b0;
    end else begin
      lock_rst_en_q <= lock_rst_en_d;
      mult_fld_q <= mult_fld_d;
      relock_q <= relock_d;
    end
  end

  // Lost-lock flag: a loss in the same cycle as a clearing write wins
  always_comb begin
    locked_prev_d = lk.locked;
    lost_d = lost_q;
    if (ctrl_wr) begin
      lost_d = 1'b0;
    end
    if (lost_lock && pll_mode) begin
      lost_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      locked_prev_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      locked_prev_q <= locked_prev_d;
      lost_q <= lost_d;
    end
  end

  // Lock-loss request, held while enabled and unlocked in the PLL modes
  always_comb begin
    rst_req_d = 1'b0;
    if (pll_mode && lock_rst_en_q && (lost_lock || !lk.locked)) begin
      rst_req_d = 1'b1;
    end
    rst_out_d = force_reset_out_bit || rst_req_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_req_q <= 1'b0;
      rst_out_q <= 1'b1;
    end else begin
      rst_req_q <= rst_req_d;
      rst_out_q <= rst_out_d;
    end
  end

  // Crystal amplifier and clock output
  always_comb begin
    osc_out_d = !osc_in_pin && pll_mode;
    clk_out_d = sys_clock_out_en && !clk_out_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_out_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      osc_out_q <= osc_out_d;
      clk_out_q <= clk_out_d;
    end
  end

  // Register answer, one cycle after the request
  always_comb begin
    rdata_d = 16'h0;
    ack_d = 1'b0;
    err_d = 1'b0;
    if (hit_ctrl || hit_stat) begin
      if (!reg_super) begin
        err_d = 1'b1;
      end else begin
        ack_d = 1'b1;
        if (hit_ctrl) begin
          rdata_d = ctrl_image(lock_rst_en_q, mult_fld_q);
        end else begin
          rdata_d = stat_image(mode_q, lk.locked, lost_q);
        end
      end
    end else if (reg_sel) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  // Effective multiplication factor
  always_comb begin
    case (mode_q)
      clkc_pkg::CLKC_NORMAL: mult_d = fld_to_mult(mult_fld_q);
      clkc_pkg::CLKC_ONE2ONE: mult_d = 4'h1;
      default: mult_d = 4'h1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mult_q <= 4'h1;
    end else begin
      mult_q <= mult_d;
    end
  end

  // Outputs
  assign osc_out_pin = osc_out_q;
  assign sys_clock_out_pin = clk_out_q;
  assign reset_out_pin = rst_out_q;
  assign lock_loss_reset_req = rst_req_q;
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_err = err_q;
  assign mult_factor = mult_q;
  assign pll_locked = locked_prev_q;
endmodule

// ===== test/clkc_osc_src.sv
`timescale 1ns/10ps
module clkc_osc_src (
  // Clock and oscillator pin
  input wire logic sys_clk,
  output logic osc_in_pin
);
  int n = 0;
  initial osc_in_pin = 1'b0;
  // Reference clock, three system clocks per half period
  always @(posedge sys_clk) begin
    n = (n + 1) % 3;
    if (n == 0) osc_in_pin <= #1 ~osc_in_pin;
  end
endmodule

// ===== test/clkc_top_asserts.sv
`timescale 1ns/10ps
`include "clkc_params.svh"
module clkc_top_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic osc_out_pin,
  input wire logic sys_clock_out_pin,
  input wire logic sys_clock_out_en,
  input wire logic [1:0] clock_mode_select,
  input wire logic reset_out_pin,
  input wire logic force_reset_out_bit,
  input wire logic stop_pll_off,
  input wire logic lock_loss_reset_req,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_super,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [3:0] mult_factor,
  input wire logic pll_locked
);
  logic [2:0] arm_q;
  always_ff @(posedge sys_clk) arm_q <= {arm_q[1:0], rst_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    reg_sel && reg_wr && reg_super && reg_addr == `CLKC_SYNTH_CONTROL_ADDR;
  endsequence
  sequence s_pll;
    arm_q[2] && clock_mode_select != 2'h0;
  endsequence
  AST_ANSWER: assert property (reg_sel |=> reg_ack != reg_err) else $error("bad answer");
  AST_USER: assert property (reg_sel && !reg_super |=> reg_err && reg_rdata == 16'h0) else $error("user");
  AST_CLK_ON: assert property (sys_clock_out_en [*2] |-> sys_clock_out_pin != $past(sys_clock_out_pin))
    else $error("clock out");
  AST_FORCE: assert property (force_reset_out_bit |=> reset_out_pin) else $error("force");
  AST_EXT: assert property (arm_q[2] && clock_mode_select == 2'h0 |-> !lock_loss_reset_req && !osc_out_pin)
    else $error("ext mode");
  AST_MULT_ONE: assert property (arm_q[2] && !clock_mode_select[0] |-> mult_factor == 4'h1) else $error("mult");
  AST_LOL_SET: assert property (s_wr ##0 s_pll ##0 (reg_wdata[15] && !pll_locked) |-> ##[1:2] lock_loss_reset_req)
    else $error("lol set");
  AST_RELOCK: assert property (s_wr ##0 s_pll ##0 (clock_mode_select[0] && reg_wdata[14:12] + 4'h2 != mult_factor)
    |-> ##[1:5] !pll_locked) else $error("relock");
  AST_STOP: assert property (s_pll ##0 $rose(stop_pll_off) |-> ##[1:5] !pll_locked) else $error("stop");
endmodule
bind clkc_top clkc_top_asserts u_chk (.*);

// ===== test/tb_top.sv
`timescale 1ns/10ps
`include "clkc_params.svh"
module tb_top;
  logic sys_clk, rst_n, osc_in_pin, osc_out_pin, sys_clock_out_pin, sys_clock_out_en, reset_out_pin;
  logic force_reset_out_bit, stop_pll_off, lock_loss_reset_req, reg_sel, reg_wr, reg_super;
  logic reg_ack, reg_err, pll_locked;
  logic [1:0] clock_mode_select;
  logic [23:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] mult_factor;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] seed, rnd;
  int n_errors, comparisons, cycles, i;
  clkc_top #(.LOCK_CYCLES(12)) uut (.*);
  clkc_osc_src src (.sys_clk(sys_clk), .osc_in_pin(osc_in_pin));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic op(input logic w, s, input logic [23:0] a, input logic [15:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    {reg_sel, reg_wr, reg_super, reg_addr, reg_wdata} = {1'b1, w, s, a, d};
    step(1);
    reg_sel = 1'b0;
    step(1);
  endtask
  task automatic wait_lock();
    step(3);
    for (int k = 0; k < 200 && pll_locked !== 1'b1; k++) step(1);
    chk("pll_locked", 16'h1, {15'h0, pll_locked});
  endtask
  task automatic do_reset(input logic [1:0] m);
    {rst_n, clock_mode_select} = {1'b0, m};
    step(8);
    rst_n = 1'b1;
    step(2);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge sys_clk) if (reg_ack === 1'b1 || reg_err === 1'b1) begin
    e = exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff;
    chk("reg_err", {15'h0, e[32]}, {15'h0, reg_err});
    chk("reg_rdata", e[15:0], reg_rdata & e[31:16]);
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_clock_out_en, force_reset_out_bit, stop_pll_off, reg_sel, reg_wr, reg_super} = 6'h0;
    {reg_addr, reg_wdata, seed} = {40'h0, 32'h1461};
    #1 do_reset(2'h3);
    op(1'b0, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h0, {17'h0f000, 16'h1000});
    wait_lock();
    op(1'b1, 1'b0, `CLKC_SYNTH_CONTROL_ADDR, 16'h7000, {1'b1, 32'h0});
    op(1'b0, 1'b0, `CLKC_SYNTH_STATUS_ADDR, 16'h0, {1'b1, 32'h0});
    op(1'b0, 1'b1, 24'h120004, 16'h0, {1'b1, 32'h0});
    op(1'b0, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h0, {17'h0f000, 16'h1000});
    op(1'b0, 1'b1, `CLKC_SYNTH_STATUS_ADDR, 16'h0, {17'h000c8, 16'h0008});
    sys_clock_out_en = 1'b1;
    step(2);
    rnd[0] = sys_clock_out_pin;
    step(1);
    chk("sys_clock_out_pin", {15'h0, ~rnd[0]}, {15'h0, sys_clock_out_pin});
    for (i = 1; i < 9; i++) begin
      rnd = $random(seed);
      op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, {1'b0, i[2:0], rnd[11:0]}, 33'h0);
      op(1'b0, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h0, {17'h0f000, 1'b0, i[2:0], 12'h0});
      wait_lock();
      chk("mult_factor", {12'h0, {1'b0, i[2:0]} + 4'h2}, {12'h0, mult_factor});
    end
    sys_clock_out_en = 1'b0;
    op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h8000, 33'h0);
    step(4);
    chk("lock_loss_reset_req", 16'h0, {15'h0, lock_loss_reset_req});
    stop_pll_off = 1'b1;
    step(6);
    chk("reset_out_pin", 16'h1, {15'h0, reset_out_pin});
    stop_pll_off = 1'b0;
    op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h0, 33'h0);
    wait_lock();
    chk("reset_out_pin", 16'h0, {15'h0, reset_out_pin});
    force_reset_out_bit = 1'b1;
    step(2);
    chk("reset_out_pin", 16'h1, {15'h0, reset_out_pin});
    force_reset_out_bit = 1'b0;
    do_reset(2'h2);
    op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'hd000, 33'h0);
    chk("lock_loss_reset_req", 16'h1, {15'h0, lock_loss_reset_req});
    chk("mult_factor", 16'h1, {12'h0, mult_factor});
    op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'h5000, 33'h0);
    wait_lock();
    op(1'b0, 1'b1, `CLKC_SYNTH_STATUS_ADDR, 16'h0, {17'h000c0, 16'h0040});
    do_reset(2'h0);
    op(1'b1, 1'b1, `CLKC_SYNTH_CONTROL_ADDR, 16'hd000, 33'h0);
    stop_pll_off = 1'b1;
    step(6);
    chk("lock_loss_reset_req", 16'h0, {15'h0, lock_loss_reset_req});
    chk("mult_factor", 16'h1, {12'h0, mult_factor});
    chk("osc_out_pin", 16'h0, {15'h0, osc_out_pin});
    op(1'b0, 1'b1, `CLKC_SYNTH_STATUS_ADDR, 16'h0, {17'h000c0, 16'h0080});
    tally_and_finish();
  end
endmodule
